// ===== tsa_cfg.svh
`ifndef TSA_CFG_SVH
`define TSA_CFG_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define TSA_CLK_NS         10
`define TSA_BUS_STALL_TIMEOUT_MIN_MS    25
`define TSA_BUS_STALL_TIMEOUT_MAX_MS    35
`define TSA_BUS_STALL_TIMEOUT_CYC       (`TSA_BUS_STALL_TIMEOUT_MIN_MS * 1000000 / `TSA_CLK_NS)
`define TSA_SCL_PERIOD_NS  10000
`define TSA_QTR_CYC        (`TSA_SCL_PERIOD_NS / 4 / `TSA_CLK_NS)
// ----------------------------------------
// Device address word and register pointers
// ----------------------------------------
`define TSA_DEV_CODE       4'h3
`define TSA_PTR_CAP        8'h00
`define TSA_PTR_CFG        8'h01
`define TSA_PTR_UPPER      8'h02
`define TSA_PTR_LOWER      8'h03
`define TSA_PTR_CRIT       8'h04
`define TSA_PTR_TEMP       8'h05
`define TSA_PTR_MFG        8'h06
`define TSA_PTR_DEVID      8'h07
`define TSA_PTR_BUS_STALL_TIMEOUT       8'h22
`define TSA_PTR_RST        8'h00
`define TSA_CAP_VAL        16'h00D7
`define TSA_LIMIT_RST      16'h0000
// ----------------------------------------
// Configuration word fields
// ----------------------------------------
`define TSA_CFG_MODE       0
`define TSA_CFG_CRIT_ONLY  2
`define TSA_CFG_EN         3
`define TSA_CFG_CLR        5
`define TSA_CFG_HYST_LSB   9
`define TSA_BUS_STALL_TIMEOUT_EN        0
// Hysteresis in 1/16 degree steps
`define TSA_HYST_0         17'h00000
`define TSA_HYST_1         17'h00018
`define TSA_HYST_2         17'h00030
`define TSA_HYST_3         17'h00060
// ----------------------------------------
// Host command port
// ----------------------------------------
`define TSA_H_CTRL         8'h00
`define TSA_H_PTR          8'h04
`define TSA_H_WDATA        8'h08
`define TSA_H_STAT         8'h0C
`define TSA_H_RDATA        8'h10
`define TSA_OP_WRITE       2'h1
`define TSA_OP_READ        2'h2
`define TSA_OP_RECOVER     2'h3
`endif

// ===== tsa_pkg.sv
package tsa_pkg;
  // Device serial engine states
  typedef enum logic [6:0] {
    DS_IDLE     = 7'b0000001,
    DS_ADDR     = 7'b0000010,
    DS_ADDR_ACK = 7'b0000100,
    DS_WR       = 7'b0001000,
    DS_WR_ACK   = 7'b0010000,
    DS_RD       = 7'b0100000,
    DS_RD_ACK   = 7'b1000000
  } tsa_dstate_t;

  // Host bus item kinds
  typedef enum logic [3:0] {
    HS_IDLE  = 4'b0001,
    HS_START = 4'b0010,
    HS_BYTE  = 4'b0100,
    HS_STOP  = 4'b1000
  } tsa_hstate_t;

  typedef struct packed {
    tsa_hstate_t kind;
    logic        rd;
    logic        ack;
    logic [7:0]  data;
  } tsa_item_t;
endpackage

// ===== tsa_if.sv
`timescale 1ns/1ps
interface tsa_if;
  logic scl;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic dev_alert_oe;
  logic sda;
  logic alert_n;

  // Open-drain wires with pull-ups
  assign sda     = ~(host_sda_oe | dev_sda_oe);
  assign alert_n = ~dev_alert_oe;

  modport dev  (input scl, input sda, output dev_sda_oe, output dev_alert_oe);
  modport host (output scl, output host_sda_oe, input sda, input alert_n);
endinterface

// ===== tsa_device.sv
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "tsa_cfg.svh"

// Functional notes
// - Data changes only while clock low
// - SDA fall, SCL high: start before command
// - SDA rise, SCL high: stop, then standby
// - Standby at power-up and after stop
// - Eight-bit words, receiver acks ninth clock
// - Most significant bit first, both directions
// - Recovery: start, nine clocks, start, stop
// - Address upper nibble 0011, then strap bits
// - Address LSB high reads, low writes
// - Match acks; mismatch no ack, standby
// - Temperature latched continuously, latest read back
// - Interrupt mode holds until clear bit five
// - Config bit 0 picks interrupt or comparator
// - Comparator alert follows the condition
// - Critical alert holds until below limit-hysteresis
// - All comparisons use programmed hysteresis
// - Alert on entering and leaving window
// - Pointer resets to 00h, monitoring starts
// - Power-on limits, mode, hysteresis, timeout zero
// - Timeout resets interface on long clock-low
// - Controller keeps clock at least 10 kHz
// - Sample on clock rise, shift on fall
module tsa_device
  import tsa_pkg::*;
#(
  parameter int unsigned BUS_STALL_TIMEOUT_CYC = `TSA_BUS_STALL_TIMEOUT_CYC,
  parameter logic [15:0] MFG_ID   = 16'h0A5A,  // Arbitrary value
  parameter logic [15:0] DEV_ID   = 16'h5A01   // Arbitrary value
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  tsa_if.dev               bus,
  input  wire logic        strap_addr_bit0,
  input  wire logic        strap_addr_bit1,
  input  wire logic        strap_addr_bit2,
  input  wire logic [15:0] temp_in,
  input  wire logic        temp_valid,
  output logic             standby
);

  // Stall counter is 24 bits wide; a one-cycle window would fire on any low clock
  if (BUS_STALL_TIMEOUT_CYC < 2 || BUS_STALL_TIMEOUT_CYC > 32'h00FFFFFF) begin : g_bus_stall_timeout_chk
    $error("BUS_STALL_TIMEOUT_CYC out of range");
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0]  s1_q, s2_q, s3_q, filt_q, prev_q;
  logic [1:0]  agree;
  logic        scl_f, sda_f, rise_p, fall_p, start_p, stop_p;

  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s1_q   <= 2'h3;
      s2_q   <= 2'h3;
      s3_q   <= 2'h3;
      filt_q <= 2'h3;
      prev_q <= 2'h3;
    end else begin
      s1_q   <= {bus.sda, bus.scl};
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= (agree & s2_q) | (~agree & filt_q);
      prev_q <= filt_q;
    end
  end

  assign agree   = s2_q ~^ s3_q;
  assign scl_f   = filt_q[0];
  assign sda_f   = filt_q[1];
  assign rise_p  = scl_f & ~prev_q[0];
  assign fall_p  = ~scl_f & prev_q[0];
  // Data edge under a high clock is framing, never data
  assign start_p = scl_f & prev_q[0] & prev_q[1] & ~sda_f;
  assign stop_p  = scl_f & prev_q[0] & ~prev_q[1] & sda_f;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  tsa_dstate_t st_q;
  logic [3:0]  bit_q;
  logic [7:0]  sh_q, msb_q, ptr_q;
  logic [1:0]  widx_q, hyst_q;
  logic        oe_q, rw_q, half_q, mack_q, sby_q, wp_q, wr_q;
  logic        mode_q, crit_only_q, en_q, bus_stall_timeout_en_q;
  logic [15:0] upper_q, lower_q, crit_q, temp_q, rd_word;
  logic [23:0] tcnt_q;
  logic        bus_stall_timeout_hit, match, clr_p;

  // Byte of a register word picked for shifting out
  function automatic logic [7:0] byte_of(input logic [15:0] w, input logic hi);
    byte_of = hi ? w[15:8] : w[7:0];
  endfunction

  assign match    = (sh_q[7:4] == `TSA_DEV_CODE) &&
                    (sh_q[3:1] == {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0});
  assign bus_stall_timeout_hit = bus_stall_timeout_en_q && (tcnt_q == 24'(BUS_STALL_TIMEOUT_CYC - 1));
  assign clr_p    = wr_q && (ptr_q == `TSA_PTR_CFG) && sh_q[`TSA_CFG_CLR];

  // ----------------------------------------
  // Bus stall timer
  // ----------------------------------------
  // Counts only while a transfer is open; 10 kHz clocks never reach it
  always_ff @(posedge core_clk) begin
    if (sys_rst || !bus_stall_timeout_en_q || scl_f || st_q == DS_IDLE) begin
      tcnt_q <= 24'h000000;
    end else if (!bus_stall_timeout_hit) begin
      tcnt_q <= tcnt_q + 24'h000001;
    end
  end

  // ----------------------------------------
  // Serial engine
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q   <= DS_IDLE;
      bit_q  <= 4'h0;
      sh_q   <= 8'h00;
      msb_q  <= 8'h00;
      oe_q   <= 1'b0;
      rw_q   <= 1'b0;
      widx_q <= 2'h0;
      half_q <= 1'b0;
      mack_q <= 1'b0;
      sby_q  <= 1'b1;
      wp_q   <= 1'b0;
      wr_q   <= 1'b0;
    end else begin
      wp_q <= 1'b0;
      wr_q <= 1'b0;
      if (bus_stall_timeout_hit) begin
        st_q  <= DS_IDLE;
        oe_q  <= 1'b0;
        sby_q <= 1'b1;
      end else if (start_p) begin
        st_q   <= DS_ADDR;
        bit_q  <= 4'h0;
        oe_q   <= 1'b0;
        widx_q <= 2'h0;
      end else if (stop_p) begin
        st_q  <= DS_IDLE;
        oe_q  <= 1'b0;
        sby_q <= 1'b1;
      end else if (rise_p) begin
        // Inputs sampled on the rising clock
        unique case (st_q)
          DS_ADDR, DS_WR: begin
            sh_q  <= {sh_q[6:0], sda_f};
            bit_q <= bit_q + 4'h1;
          end
          DS_RD:     bit_q  <= bit_q + 4'h1;
          DS_RD_ACK: mack_q <= ~sda_f;
          DS_IDLE, DS_ADDR_ACK, DS_WR_ACK: ;
        endcase
      end else if (fall_p) begin
        // Outputs change on the falling clock
        unique case (st_q)
          DS_ADDR: if (bit_q == 4'h8) begin
            if (match) begin
              st_q  <= DS_ADDR_ACK;
              oe_q  <= 1'b1;
              rw_q  <= sh_q[0];
              sby_q <= 1'b0;
            end else begin
              st_q  <= DS_IDLE;
              sby_q <= 1'b1;
            end
          end
          DS_ADDR_ACK: begin
            bit_q  <= 4'h0;
            half_q <= 1'b1;
            if (rw_q) begin
              st_q <= DS_RD;
              sh_q <= byte_of(rd_word, 1'b1);
              oe_q <= ~rd_word[15];
            end else begin
              st_q <= DS_WR;
              oe_q <= 1'b0;
            end
          end
          DS_WR: if (bit_q == 4'h8) begin
            st_q <= DS_WR_ACK;
            oe_q <= 1'b1;
            unique case (widx_q)
              2'h0: begin
                wp_q   <= 1'b1;
                widx_q <= 2'h1;
              end
              2'h1: begin
                msb_q  <= sh_q;
                widx_q <= 2'h2;
              end
              default: begin
                wr_q   <= 1'b1;
                widx_q <= 2'h1;
              end
            endcase
          end
          DS_WR_ACK: begin
            st_q  <= DS_WR;
            oe_q  <= 1'b0;
            bit_q <= 4'h0;
          end
          DS_RD: if (bit_q == 4'h8) begin
            st_q <= DS_RD_ACK;
            oe_q <= 1'b0;  // Controller owns the ninth clock
          end else begin
            oe_q <= ~sh_q[6];
            sh_q <= {sh_q[6:0], 1'b0};
          end
          DS_RD_ACK: begin
            bit_q <= 4'h0;
            if (mack_q) begin
              st_q   <= DS_RD;
              half_q <= ~half_q;
              sh_q   <= byte_of(rd_word, ~half_q);
              oe_q   <= half_q ? ~rd_word[7] : ~rd_word[15];
            end else begin
              st_q <= DS_IDLE;
            end
          end
          DS_IDLE: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Registers reached over the serial link
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ptr_q       <= `TSA_PTR_RST;
      mode_q      <= 1'b0;
      crit_only_q <= 1'b0;
      en_q        <= 1'b0;
      hyst_q      <= 2'h0;
      upper_q     <= `TSA_LIMIT_RST;
      lower_q     <= `TSA_LIMIT_RST;
      crit_q      <= `TSA_LIMIT_RST;
      bus_stall_timeout_en_q   <= 1'b0;
    end else if (wp_q) begin
      ptr_q <= sh_q;
    end else if (wr_q) begin
      unique case (ptr_q)
        `TSA_PTR_CFG: begin
          mode_q      <= sh_q[`TSA_CFG_MODE];
          crit_only_q <= sh_q[`TSA_CFG_CRIT_ONLY];
          en_q        <= sh_q[`TSA_CFG_EN];
          hyst_q      <= msb_q[`TSA_CFG_HYST_LSB-8 +: 2];
        end
        `TSA_PTR_UPPER: upper_q   <= {msb_q, sh_q};
        `TSA_PTR_LOWER: lower_q   <= {msb_q, sh_q};
        `TSA_PTR_CRIT:  crit_q    <= {msb_q, sh_q};
        `TSA_PTR_BUS_STALL_TIMEOUT:  bus_stall_timeout_en_q <= sh_q[`TSA_BUS_STALL_TIMEOUT_EN];
        default: ;  // Read-only and reserved words ignore writes
      endcase
    end
  end

  // Read mux; clear bit always reads zero
  always_comb begin
    unique case (ptr_q)
      `TSA_PTR_CAP:   rd_word = `TSA_CAP_VAL;
      `TSA_PTR_CFG:   rd_word = {5'h00, hyst_q, 5'h00, en_q, crit_only_q, 1'b0, mode_q};
      `TSA_PTR_UPPER: rd_word = upper_q;
      `TSA_PTR_LOWER: rd_word = lower_q;
      `TSA_PTR_CRIT:  rd_word = crit_q;
      `TSA_PTR_TEMP:  rd_word = temp_q;
      `TSA_PTR_MFG:   rd_word = MFG_ID;
      `TSA_PTR_DEVID: rd_word = DEV_ID;
      `TSA_PTR_BUS_STALL_TIMEOUT:  rd_word = {15'h0000, bus_stall_timeout_en_q};
      default:        rd_word = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // Temperature latch and alert
  // ----------------------------------------
  // Converter result latched on every strobe, standby or not
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      temp_q <= 16'h0000;
    end else if (temp_valid) begin
      temp_q <= temp_in;
    end
  end

  logic signed [16:0] t_s, up_s, lo_s, cr_s, hy_s;
  logic               win_q, win_prev_q, hot_q, irq_q, alert_q;

  assign t_s  = {temp_q[15], temp_q};
  assign up_s = {upper_q[15], upper_q};
  assign lo_s = {lower_q[15], lower_q};
  assign cr_s = {crit_q[15], crit_q};
  always_comb begin
    unique case (hyst_q)
      2'h0: hy_s = `TSA_HYST_0;
      2'h1: hy_s = `TSA_HYST_1;
      2'h2: hy_s = `TSA_HYST_2;
      2'h3: hy_s = `TSA_HYST_3;
    endcase
  end

  // Conditions set on the limit, release only past it by the hysteresis
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      win_q      <= 1'b0;
      win_prev_q <= 1'b0;
      hot_q      <= 1'b0;
    end else begin
      win_prev_q <= win_q;
      if (t_s > up_s || t_s < lo_s) begin
        win_q <= 1'b1;
      end else if (t_s <= up_s - hy_s && t_s >= lo_s + hy_s) begin
        win_q <= 1'b0;
      end
      if (t_s > cr_s) begin
        hot_q <= 1'b1;
      end else if (t_s < cr_s - hy_s) begin
        hot_q <= 1'b0;
      end
    end
  end

  // Sticky event on both window edges; an edge beats a clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else if (en_q && win_q != win_prev_q) begin
      irq_q <= 1'b1;
    end else if (clr_p) begin
      irq_q <= 1'b0;
    end
  end

  // Critical overrides; afterwards the bit-0 mode takes over again unless critical-only bit 2 is set
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= en_q & (hot_q | (~crit_only_q & (mode_q ? irq_q : win_q)));
    end
  end

  assign bus.dev_sda_oe   = oe_q;
  assign bus.dev_alert_oe = alert_q;
  assign standby          = sby_q;

endmodule  // tsa_device

// ===== tsa_host.sv
`timescale 1ns/1ps
`include "tsa_cfg.svh"

module tsa_host
  import tsa_pkg::*;
#(
  parameter int unsigned QTR_CYC = `TSA_QTR_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  tsa_if.host              bus,
  input  wire logic [7:0]  cmd_addr,
  input  wire logic [31:0] cmd_wdata,
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  output logic [31:0]      cmd_rdata
);

  // Quarter counter is 16 bits; below two cycles the line filters lose edges
  if (QTR_CYC < 2 || QTR_CYC > 65535) begin : g_qtr_chk
    $error("QTR_CYC out of range");
  end

  // ----------------------------------------
  // Transfer scripts
  // ----------------------------------------
  // Recovery script: start, nine released clocks, start, stop
  function automatic tsa_item_t item_f(input logic [1:0] op, input logic [3:0] idx,
                                       input logic [6:0] ta, input logic [7:0] p,
                                       input logic [15:0] wd);
    tsa_item_t it;
    it = '{kind: HS_IDLE, rd: 1'b0, ack: 1'b0, data: 8'h00};
    unique case ({op, idx})
      {`TSA_OP_WRITE, 4'h0}, {`TSA_OP_READ, 4'h0}, {`TSA_OP_READ, 4'h3},
      {`TSA_OP_RECOVER, 4'h0}, {`TSA_OP_RECOVER, 4'h2}: it.kind = HS_START;
      {`TSA_OP_WRITE, 4'h1}, {`TSA_OP_READ, 4'h1}: it = '{HS_BYTE, 1'b0, 1'b0, {ta, 1'b0}};
      {`TSA_OP_WRITE, 4'h2}, {`TSA_OP_READ, 4'h2}: it = '{HS_BYTE, 1'b0, 1'b0, p};
      {`TSA_OP_WRITE, 4'h3}: it = '{HS_BYTE, 1'b0, 1'b0, wd[15:8]};
      {`TSA_OP_WRITE, 4'h4}: it = '{HS_BYTE, 1'b0, 1'b0, wd[7:0]};
      {`TSA_OP_READ, 4'h4}:  it = '{HS_BYTE, 1'b0, 1'b0, {ta, 1'b1}};
      {`TSA_OP_READ, 4'h5}:  it = '{HS_BYTE, 1'b1, 1'b1, 8'h00};
      {`TSA_OP_READ, 4'h6}, {`TSA_OP_RECOVER, 4'h1}: it = '{HS_BYTE, 1'b1, 1'b0, 8'h00};
      {`TSA_OP_WRITE, 4'h5}, {`TSA_OP_READ, 4'h7}, {`TSA_OP_RECOVER, 4'h3}: it.kind = HS_STOP;
      default: ;  // Past the end of a script
    endcase
    return it;
  endfunction

  // ----------------------------------------
  // Command registers
  // ----------------------------------------
  logic [1:0]  op_q;
  logic [6:0]  ta_q;
  logic [7:0]  ptr_q;
  logic [15:0] wd_q, rdat_q;
  logic        busy_q, nack_q, go;

  // Writes are ignored while a transfer runs
  assign go = cmd_wr && !busy_q && cmd_addr == `TSA_H_CTRL && cmd_wdata[1:0] != 2'h0;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      op_q  <= 2'h0;
      ta_q  <= 7'h00;
      ptr_q <= 8'h00;
      wd_q  <= 16'h0000;
    end else if (cmd_wr && !busy_q) begin
      unique case (cmd_addr)
        `TSA_H_CTRL: begin
          op_q <= cmd_wdata[1:0];
          ta_q <= cmd_wdata[14:8];
        end
        `TSA_H_PTR:   ptr_q <= cmd_wdata[7:0];
        `TSA_H_WDATA: wd_q  <= cmd_wdata[15:0];
        default: ;
      endcase
    end
  end

  // Read data only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst || !cmd_rd) begin
      cmd_rdata <= 32'h00000000;
    end else begin
      unique case (cmd_addr)
        `TSA_H_CTRL:  cmd_rdata <= {17'h00000, ta_q, 6'h00, op_q};
        `TSA_H_PTR:   cmd_rdata <= {24'h000000, ptr_q};
        `TSA_H_WDATA: cmd_rdata <= {16'h0000, wd_q};
        `TSA_H_STAT:  cmd_rdata <= {30'h00000000, nack_q, busy_q};
        `TSA_H_RDATA: cmd_rdata <= {16'h0000, rdat_q};
        default:      cmd_rdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // Bus engine: each slot is four quarters of the clock period
  // ----------------------------------------
  logic [2:0]  sy_q;
  logic        sda_f;
  tsa_item_t   it_q;
  logic [3:0]  idx_q, slot_q;
  logic [1:0]  q_q;
  logic [15:0] qc_q;
  logic [7:0]  rx_q;
  logic        bit_v, scl_q, oe_q;
  tsa_item_t   nxt_it;

  // Next item of the running script
  assign nxt_it = item_f(op_q, idx_q, ta_q, ptr_q, wd_q);

  // Read-back of the data line through three stages
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sy_q  <= 3'h7;
      sda_f <= 1'b1;
    end else begin
      sy_q <= {sy_q[1:0], bus.sda};
      if (sy_q[1] == sy_q[2]) begin
        sda_f <= sy_q[1];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      nack_q <= 1'b0;
      it_q   <= item_f(2'h0, 4'h0, 7'h00, 8'h00, 16'h0000);
      idx_q  <= 4'h0;
      slot_q <= 4'h0;
      q_q    <= 2'h0;
      qc_q   <= 16'h0000;
      rx_q   <= 8'h00;
      rdat_q <= 16'h0000;
    end else if (go) begin
      busy_q <= 1'b1;
      nack_q <= 1'b0;
      it_q   <= item_f(cmd_wdata[1:0], 4'h0, 7'h00, 8'h00, 16'h0000);
      idx_q  <= 4'h1;
      slot_q <= 4'h0;
      q_q    <= 2'h0;
      qc_q   <= 16'h0000;
    end else if (busy_q && qc_q == 16'(QTR_CYC - 1)) begin
      qc_q <= 16'h0000;
      q_q  <= q_q + 2'h1;
      // Sample in the middle of the high clock
      if (q_q == 2'h1 && it_q.kind == HS_BYTE) begin
        if (slot_q != 4'h8) begin
          rx_q <= {rx_q[6:0], sda_f};
        end else if (!it_q.rd && sda_f) begin
          nack_q <= 1'b1;
        end
      end
      if (q_q == 2'h3) begin
        if (it_q.kind == HS_BYTE && slot_q != 4'h8) begin
          slot_q <= slot_q + 4'h1;
        end else begin
          slot_q <= 4'h0;
          if (it_q.kind == HS_BYTE && it_q.rd && op_q == `TSA_OP_READ) begin
            if (it_q.ack) begin
              rdat_q[15:8] <= rx_q;
            end else begin
              rdat_q[7:0] <= rx_q;
            end
          end
          // Missing acknowledge cuts the script short with a stop
          if (it_q.kind == HS_BYTE && nack_q) begin
            it_q  <= '{HS_STOP, 1'b0, 1'b0, 8'h00};
            idx_q <= 4'hF;
          end else begin
            it_q  <= nxt_it;
            idx_q <= idx_q + 4'h1;
            if (nxt_it.kind == HS_IDLE) begin
              busy_q <= 1'b0;
            end
          end
        end
      end
    end else if (busy_q) begin
      qc_q <= qc_q + 16'h0001;
    end
  end

  // Bit on the line: data, or released for the target's answer
  always_comb begin
    if (slot_q == 4'h8) begin
      bit_v = it_q.rd ? ~it_q.ack : 1'b1;
    end else begin
      bit_v = it_q.rd ? 1'b1 : it_q.data[3'h7 - slot_q[2:0]];
    end
  end

  // Pin drive; byte data moves only in the low quarters, start and stop move it in quarter 2 with the clock high
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      oe_q  <= 1'b0;
    end else begin
      unique case (it_q.kind)
        HS_IDLE: begin
          scl_q <= 1'b1;
          oe_q  <= 1'b0;
        end
        HS_START: begin
          scl_q <= q_q == 2'h1 || q_q == 2'h2;
          oe_q  <= q_q[1];
        end
        HS_STOP: begin
          scl_q <= q_q != 2'h0;
          oe_q  <= ~q_q[1];
        end
        HS_BYTE: begin
          scl_q <= q_q == 2'h1 || q_q == 2'h2;
          oe_q  <= ~bit_v;
        end
      endcase
    end
  end

  assign bus.scl         = scl_q;
  assign bus.host_sda_oe = oe_q;

endmodule  // tsa_host

// ===== tsa_sva.sv
`timescale 1ns/1ps
module tsa_sva (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic dev_alert_oe,
  input wire logic sda,
  input wire logic alert_n
);
  // ----
  // Frame tracking
  // ----
  logic       scl_q;
  logic       sda_q;
  logic       frame_q;
  logic [7:0] bits_q;
  logic       start_w;
  logic       stop_w;

  // Line conditions seen on the raw pins
  assign start_w = scl && scl_q && sda_q && !sda;
  assign stop_w  = scl && scl_q && !sda_q && sda;

  // Last pin levels
  always_ff @(posedge core_clk) begin
    scl_q <= scl;
    sda_q <= sda;
  end

  // Clock rises since the last start; saturates so long reads cannot wrap
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      frame_q <= 1'b0;
      bits_q  <= 8'h00;
    end else if (start_w) begin
      frame_q <= 1'b1;
      bits_q  <= 8'h00;
    end else if (stop_w) begin
      frame_q <= 1'b0;
    end else if (scl && !scl_q && bits_q != 8'hFF) begin
      bits_q  <= bits_q + 8'h01;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ----
  // Checks
  // ----
  a_rise_low: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("device took data line while clock high");
  a_stable_high: assert property (scl && scl_q |-> $stable(dev_sda_oe))
    else $error("device data changed during clock high");
  a_start_free: assert property (start_w |-> !dev_sda_oe [*4])
    else $error("device drives data after a start");
  a_hold_fall: assert property ($rose(dev_sda_oe) |->
    dev_sda_oe throughout (##[1:24] $fell(scl)))
    else $error("device data not held to the next clock fall");
  a_late_release: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("device released data while clock high");
  a_addr_quiet: assert property (frame_q && bits_q < 8'h08 |-> !dev_sda_oe)
    else $error("device drives during the address byte");
  a_idle_quiet: assert property (!frame_q |-> !dev_sda_oe)
    else $error("device drives data outside a frame");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !dev_alert_oe && !dev_sda_oe)
    else $error("outputs active after reset");
endmodule // tsa_sva

// ===== tsa_tb.sv
`timescale 1ns/1ps
`include "tsa_cfg.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  import tsa_pkg::*;
  // Row: op 0 temp, 1 write, 2 read, 3 recover, 4 read wrong target
  typedef struct packed {
    logic [2:0]  op;
    logic [7:0]  pt;
    logic [15:0] wd;
    logic [16:0] ex;
  } tsa_row_t;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [2:0]  strap = 3'h5;
  logic [15:0] temp_in = 16'h0000;
  logic        temp_valid = 1'b0;
  logic [7:0]  cmd_addr = 8'h00;
  logic [31:0] cmd_wdata = 32'h0;
  logic        cmd_wr = 1'b0;
  logic        cmd_rd = 1'b0;
  logic [31:0] cmd_rdata;
  logic        standby;
  int          miscompares = 0;
  int          checks = 0;
  int          cyc = 0;
  tsa_row_t    rows [26] = '{
    '{3'h2, 8'h00, 16'h0, 17'h000D7}, '{3'h2, 8'h01, 16'h0, 17'h0},
    '{3'h2, 8'h22, 16'h0, 17'h0}, '{3'h4, 8'h00, 16'h0, 17'h10000},
    '{3'h1, 8'h02, 16'h0190, 17'h0}, '{3'h1, 8'h03, 16'h0050, 17'h0},
    '{3'h1, 8'h04, 16'h0640, 17'h0}, '{3'h1, 8'h00, 16'h1234, 17'h0},
    '{3'h2, 8'h00, 16'h0, 17'h000D7}, '{3'h2, 8'h02, 16'h0, 17'h00190},
    '{3'h0, 8'h00, 16'h0200, 17'h1}, '{3'h1, 8'h01, 16'h0008, 17'h0},
    '{3'h0, 8'h00, 16'h0200, 17'h0}, '{3'h0, 8'h00, 16'h0100, 17'h1},
    '{3'h0, 8'h00, 16'h0030, 17'h0}, '{3'h0, 8'h00, 16'h0100, 17'h1},
    '{3'h1, 8'h01, 16'h0009, 17'h0}, '{3'h0, 8'h00, 16'h0200, 17'h0},
    '{3'h0, 8'h00, 16'h0100, 17'h0}, '{3'h1, 8'h01, 16'h0029, 17'h0},
    '{3'h0, 8'h00, 16'h0100, 17'h1},
    '{3'h1, 8'h01, 16'h020C, 17'h0}, '{3'h0, 8'h00, 16'h0700, 17'h0},
    '{3'h0, 8'h00, 16'h0630, 17'h0}, '{3'h1, 8'h22, 16'h0001, 17'h0},
    '{3'h2, 8'h22, 16'h0, 17'h00001}};
  tsa_if bus ();
  tsa_device #(.BUS_STALL_TIMEOUT_CYC(200)) tsa_device_i (.core_clk, .sys_rst, .bus(bus.dev),
    .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]), .strap_addr_bit2(strap[2]),
    .temp_in, .temp_valid, .standby);
  // Eight-cycle clock-low phase stays far inside the stall window
  tsa_host #(.QTR_CYC(4)) tsa_host_i (.core_clk, .sys_rst, .bus(bus.host), .cmd_addr,
    .cmd_wdata, .cmd_wr, .cmd_rd, .cmd_rdata);
  tsa_sva tsa_sva_i (.core_clk, .sys_rst, .scl(bus.scl), .host_sda_oe(bus.host_sda_oe),
    .dev_sda_oe(bus.dev_sda_oe), .dev_alert_oe(bus.dev_alert_oe), .sda(bus.sda),
    .alert_n(bus.alert_n));
  // ----
  // Clock and hang guard
  // ----
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic hwr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk); cmd_addr <= a; cmd_wdata <= d; cmd_wr <= 1'b1;
    @(posedge core_clk); cmd_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic hrd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk); cmd_addr <= a; cmd_rd <= 1'b1;
    @(posedge core_clk); cmd_rd <= 1'b0;
    #1 d = cmd_rdata;
  endtask
  // One row: temperature step or a full bus transaction through the host
  task automatic run(input tsa_row_t r, output logic [16:0] got);
    logic [31:0] s;
    logic [31:0] d;
    int n;
    d = 32'h0;
    n = 0;
    if (r.op == 3'h0) begin
      @(posedge core_clk); temp_in <= r.wd; temp_valid <= 1'b1;
      @(posedge core_clk); temp_valid <= 1'b0;
      repeat (4) @(posedge core_clk);
      #1 got = {16'h0, bus.alert_n};
    end else begin
      hwr(`TSA_H_PTR, {24'h0, r.pt});
      hwr(`TSA_H_WDATA, {16'h0, r.wd});
      hwr(`TSA_H_CTRL, {17'h0, `TSA_DEV_CODE, strap ^ {2'h0, r.op[2]}, 6'h0,
        (r.op[2] ? 2'h2 : r.op[1:0])});
      do begin hrd(`TSA_H_STAT, s); n++; end while (s[0] !== 1'b0 && n < 4000);
      if (r.op[1:0] == 2'h2) hrd(`TSA_H_RDATA, d);
      repeat (8) @(posedge core_clk);
      `CHK(standby, 1'b1)
      got = {s[1], d[15:0]};
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    logic [16:0] g;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1 `CHK({standby, bus.alert_n}, 2'h3)
    foreach (rows[i]) begin
      run(rows[i], g);
      `CHK(g, rows[i].ex)
    end
    run('{3'h0, 8'h00, 16'h0620, 17'h1}, g);
    `CHK(g, 17'h1)
    run('{3'h3, 8'h00, 16'h0, 17'h0}, g);
    `CHK(g, 17'h0)
    run('{3'h2, 8'h05, 16'h0, 17'h0}, g);
    `CHK(g, 17'h00620)
    run('{3'h0, 8'h00, 16'h0700, 17'h0}, g);
    @(posedge core_clk); sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk); sys_rst <= 1'b0;
    #1 `CHK(bus.alert_n, 1'b1)
    run('{3'h2, 8'h04, 16'h0, 17'h0}, g);
    `CHK(g, 17'h0)
    end_of_test();
  end
endmodule // testbench
